// File: design/aisq_cfg.svh
// constants for the power-up reset sequencer
`ifndef AISQ_CFG_SVH
`define AISQ_CFG_SVH
// ************************************************************
// register map
// ************************************************************
`define AISQ_SWRST_ADDR 7'h00
`define AISQ_SWRST_BIT 0
`define AISQ_SWRST_RESET 8'h00
// ************************************************************
// timing
// ************************************************************
`define AISQ_CAL_CYCLES 200000
`define AISQ_FUSE_CYCLES 4
`endif

// File: design/aisq_pkg.sv
// types for the power-up reset sequencer
package aisq_pkg;
  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    AISQ_ST_RESET,
    AISQ_ST_FUSE,
    AISQ_ST_CAL,
    AISQ_ST_READY
  } aisq_state_e;
endpackage

// File: design/aisq_seq.sv
// power-up reset, fuse load, calibration and software reset sequencer
`timescale 1ns/1ns
`include "aisq_cfg.svh"

// Contract
// - reset release loads fuses then calibrates
// - calibration lasts about 200000 clock cycles
// - writing one to bit 0 restores defaults
// - software reset bit clears itself
// - hardware reset returns defaults at any time, software reset only in ready
module aisq_seq #(
  parameter int CAL_CYCLES = `AISQ_CAL_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // hardware reset pin, active high, asynchronous to clock
  input wire logic hw_reset_pin_in,
  // serial register write port (already decoded byte writes)
  input wire logic wr_strobe_in,
  input wire logic [6:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  // status
  output logic defaults_load_out,
  output logic cal_busy_out,
  output logic ready_out,
  output logic [7:0] swrst_reg_out
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic pin_s1;            // first synchroniser stage
    logic pin_s2;            // second synchroniser stage
    aisq_pkg::aisq_state_e st;
    logic [17:0] cnt;        // fuse and calibration counter
    logic [7:0] swrst;       // software reset register image
    logic load;              // defaults load strobe
    logic busy;
    logic rdy;
  } aisq_state_s;

  aisq_state_s s_q;
  aisq_state_s s_d;
  logic sw_hit;              // write of one to reset bit

  // ************************************************************
  // sequencing notes
  // ************************************************************
  // the reset pin is a board level, so only the second synchroniser
  // stage is ever read; the first may go metastable on a pin edge.
  // one shared counter serves the fuse copy and the calibration,
  // since the two never run at once; it is sized for the full
  // calibration count and reloaded to zero on entry to fuse copy and to calibration.
  // a software reset in ready reloads the register defaults only:
  // the capacitors are already trimmed, so rerunning the long
  // calibration would just keep the host waiting for nothing.
  // limitation: a write of one to the reset bit during fuse copy or
  // calibration is stored but performs no reset, as the host must
  // not talk to the part in that window anyway.

  // ************************************************************
  // next state
  // ************************************************************
  // single next-state process; every field starts from its old value
  always_comb begin
    s_d = s_q;
    // two-stage synchroniser for the asynchronous reset pin
    s_d.pin_s1 = hw_reset_pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.load = 1'b0;
    // software reset only counts once the part is up
    sw_hit = wr_strobe_in && (wr_addr_in == `AISQ_SWRST_ADDR) &&
             wr_data_in[`AISQ_SWRST_BIT] && (s_q.st == aisq_pkg::AISQ_ST_READY);
    // plain byte store; reset state and self-clear override it below
    if (wr_strobe_in && (wr_addr_in == `AISQ_SWRST_ADDR)) begin
      s_d.swrst = wr_data_in;
    end
    // main sequencer: reset, fuse copy, calibration, ready
    case (s_q.st)
      aisq_pkg::AISQ_ST_RESET: begin
        // hold while pin high, registers at defaults
        s_d.swrst = `AISQ_SWRST_RESET;
        s_d.busy = 1'b1;
        s_d.rdy = 1'b0;
        // leave only once the synchronised pin reads low
        if (!s_q.pin_s2) begin
          s_d.st = aisq_pkg::AISQ_ST_FUSE;
          s_d.cnt = 18'h00000;
          s_d.load = 1'b1;
        end
      end
      aisq_pkg::AISQ_ST_FUSE: begin
        // fuse image copy before calibration
        s_d.cnt = s_q.cnt + 18'h00001;
        // last fuse cycle: restart the counter for calibration
        if (s_q.cnt == 18'(`AISQ_FUSE_CYCLES - 1)) begin
          s_d.st = aisq_pkg::AISQ_ST_CAL;
          s_d.cnt = 18'h00000;
        end
      end
      aisq_pkg::AISQ_ST_CAL: begin
        // capacitor calibration window
        s_d.cnt = s_q.cnt + 18'h00001;
        // busy and ready swap in the same cycle, never overlap
        if (s_q.cnt == 18'(CAL_CYCLES - 1)) begin
          s_d.st = aisq_pkg::AISQ_ST_READY;
          s_d.busy = 1'b0;
          s_d.rdy = 1'b1;
        end
      end
      default: begin
        // ready: a software reset reloads defaults, no recalibration
        if (sw_hit) begin
          s_d.load = 1'b1;
          s_d.swrst = `AISQ_SWRST_RESET;
        end
      end
    endcase
    // hardware reset wins over state, busy and ready at any time; a load or byte store in the same cycle still lands
    if (s_q.pin_s2) begin
      s_d.st = aisq_pkg::AISQ_ST_RESET;
      s_d.busy = 1'b1;
      s_d.rdy = 1'b0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // the only clocked process; power-on reset puts every field at a constant
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    // power-on reset: busy, not ready, register at its default
    if (!rst_n_in) begin
      s_q <= '{pin_s1: 1'b0, pin_s2: 1'b0, st: aisq_pkg::AISQ_ST_RESET,
               cnt: 18'h00000, swrst: `AISQ_SWRST_RESET, load: 1'b0,
               busy: 1'b1, rdy: 1'b0};
    end else begin
      // normal clocking of the whole state image
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign defaults_load_out = s_q.load;
  assign cal_busy_out = s_q.busy;
  assign ready_out = s_q.rdy;
  assign swrst_reg_out = s_q.swrst;

  // ************************************************************
  // assertions
  // ************************************************************
  a_fuse_after_release: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == aisq_pkg::AISQ_ST_RESET && !s_q.pin_s2) |=> s_q.load)
    else $error("no defaults load after reset release");
  a_cal_ends_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == aisq_pkg::AISQ_ST_CAL && s_q.cnt == 18'(CAL_CYCLES - 1) && !s_q.pin_s2)
    |=> s_q.rdy && !s_q.busy)
    else $error("calibration end did not raise ready");
  a_busy_not_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(s_q.busy && s_q.rdy))
    else $error("busy and ready together");
  a_sw_reset_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (sw_hit && !s_q.pin_s2) |=> s_q.load)
    else $error("software reset did not reload defaults");
  a_sw_bit_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sw_hit |=> !s_q.swrst[`AISQ_SWRST_BIT])
    else $error("software reset bit did not clear");
  a_hw_reset_any: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.pin_s2 |=> (s_q.st == aisq_pkg::AISQ_ST_RESET) && !s_q.rdy)
    else $error("hardware reset not honoured");
  a_ready_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.rdy && !s_q.pin_s2) |=> s_q.rdy)
    else $error("ready dropped without hardware reset");
  a_rst_defaults: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == aisq_pkg::AISQ_ST_RESET) |=> s_q.swrst == `AISQ_SWRST_RESET)
    else $error("register not at default in reset");
  // fuse copy hands over to calibration with a fresh count
  a_fuse_to_cal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == aisq_pkg::AISQ_ST_FUSE && s_q.cnt == 18'(`AISQ_FUSE_CYCLES - 1)
     && !s_q.pin_s2)
    |=> (s_q.st == aisq_pkg::AISQ_ST_CAL) && (s_q.cnt == 18'h00000))
    else $error("fuse load did not hand over to calibration");
  // no ready before the calibration count is used up
  a_no_early_ready: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == aisq_pkg::AISQ_ST_CAL && s_q.cnt != 18'(CAL_CYCLES - 1))
    |=> !s_q.rdy && s_q.busy)
    else $error("ready raised before calibration end");
  // calibration counter steps by one every cycle
  a_cal_count_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == aisq_pkg::AISQ_ST_CAL && s_q.cnt != 18'(CAL_CYCLES - 1) && !s_q.pin_s2)
    |=> (s_q.st == aisq_pkg::AISQ_ST_CAL) && (s_q.cnt == $past(s_q.cnt) + 18'h00001))
    else $error("calibration counter skipped");
  // ready only ever comes out of calibration
  a_ready_after_cal: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(s_q.rdy) |-> ($past(s_q.st) == aisq_pkg::AISQ_ST_CAL))
    else $error("ready raised outside calibration");
  // reset state always reports busy and not ready
  a_busy_in_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.st == aisq_pkg::AISQ_ST_RESET) |-> s_q.busy && !s_q.rdy)
    else $error("reset state not reported busy");

  // ************************************************************
  // coverage of the main scenarios
  // ************************************************************
  c_power_up: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(s_q.rdy));
  c_sw_reset: cover property (@(posedge clk_in) disable iff (!rst_n_in) sw_hit);
  c_hw_in_cal: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.busy && s_q.pin_s2 && s_q.st == aisq_pkg::AISQ_ST_CAL);
  c_fuse_done: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.st == aisq_pkg::AISQ_ST_FUSE && s_q.cnt == 18'(`AISQ_FUSE_CYCLES - 1));
  c_hw_in_ready: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.rdy && s_q.pin_s2);
endmodule

// File: sim/aisq_host.sv
// host controller model: reset pin and register writes
`timescale 1ns/1ns
module aisq_host (
  // clock and device status
  input wire logic clk_in,
  input wire logic ready_in,
  // pin and write port toward the device
  output logic hw_reset_pin_out,
  output logic wr_strobe_out,
  output logic [6:0] wr_addr_out,
  output logic [7:0] wr_data_out
);
  logic ref_sel_q = 1'b0; // reference select level
  // supplies settle before the reference pin is driven
  initial begin
    hw_reset_pin_out = 1'b0;
    wr_strobe_out = 1'b0;
    wr_addr_out = 7'h7F;
    wr_data_out = 8'hA5;
    #2_000_000 ref_sel_q = 1'b1;
  end
  // pulse of 25 cycles, safely above the 20-cycle minimum
  task automatic hw_pulse();
    wait (ref_sel_q);
    repeat (3) @(posedge clk_in);
    #5 hw_reset_pin_out = 1'b1;
    repeat (25) @(posedge clk_in);
    #5 hw_reset_pin_out = 1'b0;
  endtask
  // one byte; no strobe before calibration ends, pin stays low
  task automatic send_byte(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #5 wr_strobe_out = ready_in;
    wr_addr_out = a;
    wr_data_out = d;
    @(posedge clk_in);
    #5 wr_strobe_out = 1'b0;
    wr_addr_out = ~a; // released lines must not keep a stale value
    wr_data_out = ~d;
  endtask
endmodule

// File: sim/tb_top.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
`include "aisq_cfg.svh"
module tb_top;
  localparam int CAL = 50; // shortened calibration keeps the run brief
  logic clk_in = 0, rst_n_in = 0, pin, stb, load, busy, ready;
  logic [6:0] addr;
  logic [7:0] wdat, reg_q, d;
  logic [7:0] exp_q[$]; // register image expected at each load pulse
  int failures = 0, compares = 0, n, seed = 32'hd44f;
  always #25 clk_in = ~clk_in;
  aisq_seq #(.CAL_CYCLES(CAL)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .hw_reset_pin_in(pin), .wr_strobe_in(stb), .wr_addr_in(addr), .wr_data_in(wdat),
    .defaults_load_out(load), .cal_busy_out(busy), .ready_out(ready), .swrst_reg_out(reg_q));
  aisq_host host (.clk_in(clk_in), .ready_in(ready), .hw_reset_pin_out(pin),
    .wr_strobe_out(stb), .wr_addr_out(addr), .wr_data_out(wdat));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for ready, then judge the cycles waited from the call against the calibration length
  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("cal_len", 8'h01, {7'h00, n >= CAL && n <= CAL + 12});
  endtask
  // each load pulse takes the oldest note; an unplanned one finds none
  always @(negedge clk_in) begin
    if (load === 1'b1)
      chk("load_reg", exp_q.size() ? exp_q.pop_front() : 8'hEE, reg_q);
  end
  initial begin
    exp_q.push_back(`AISQ_SWRST_RESET);
    repeat (4) @(posedge clk_in);
    #5 rst_n_in = 1'b1;
    wait_ready();
    $display("test power_up done");
    d = 8'($random(seed)) & 8'hFE;
    host.send_byte(`AISQ_SWRST_ADDR, d);
    host.send_byte(7'h05, ~d);
    chk("reg_kept", d, reg_q);
    $display("test plain_write done");
    exp_q.push_back(`AISQ_SWRST_RESET);
    host.hw_pulse();
    chk("busy", 8'h01, {7'h00, busy});
    chk("reg_clr", `AISQ_SWRST_RESET, reg_q);
    wait_ready();
    $display("test hw_reset done");
    exp_q.push_back(`AISQ_SWRST_RESET);
    host.send_byte(`AISQ_SWRST_ADDR, d | 8'h01);
    chk("self_clr", 8'h00, reg_q);
    chk("no_recal", 8'h01, {7'h00, ready});
    repeat (3) @(posedge clk_in);
    chk("pending", 8'h00, 8'(exp_q.size()));
    $display("test sw_reset done");
    print_verdict();
  end
  // watchdog: the whole run should end near 2.005 ms
  initial begin
    #3_000_000;
    failures++;
    print_verdict();
  end
endmodule
